// ==== src/spisq_pkg.sv ====
// Shared constants and types for the serial port instruction sequencer
package spisq_pkg;
  // ----------------------------------------------------------------
  // Widths and depths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int SYNC_W = 3;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [12:0] CFG_ADDR = 13'h0000;
  localparam logic [12:0] LAST_ADDR = 13'h0232;
  localparam logic [7:0] CFG_RESET = 8'h18;
  localparam int CFG_SDO_BIT = 0;
  localparam int CFG_LSB_BIT = 1;
  localparam int UPDATE_BIT = 0;

  // ----------------------------------------------------------------
  // Instruction word layout and bit counts
  // ----------------------------------------------------------------
  localparam int RW_BIT = 15;
  localparam int LEN_HI = 14;
  localparam int LEN_LO = 13;
  localparam logic [1:0] LEN_STREAM = 2'h3;
  localparam logic [3:0] BIT_LAST_INSTR = 4'hf;
  localparam logic [2:0] BIT_LAST_DATA = 3'h7;

  // ----------------------------------------------------------------
  // Synchroniser lanes
  // ----------------------------------------------------------------
  localparam int LANE_SCLK = 0;
  localparam int LANE_CSN = 1;
  localparam int LANE_DATA = 2;

  typedef enum {SQ_INSTR, SQ_DATA, SQ_DONE} spisq_state_e;

  typedef struct packed {
    logic [12:0] addr;
    logic [7:0] data;
  } spisq_wr_s;
endpackage

// ==== src/spisq_sync.sv ====
// Three-stage input synchroniser with debounced level and edge pulses
`timescale 1ns/1ps
module spisq_sync #(
  parameter int W = 3
) (
  input wire logic clock_i, // System clock
  input wire logic rstn_i, // Async reset, active low
  input wire logic [W-1:0] din_i, // Asynchronous inputs
  output logic [W-1:0] level_o, // Accepted level
  output logic [W-1:0] rise_o, // One-cycle rise pulse
  output logic [W-1:0] fall_o // One-cycle fall pulse
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_level;

  // ----------------------------------------------------------------
  // A change counts once stages two and three agree
  // ----------------------------------------------------------------
  always_comb begin
    next_level = level_o;
    for (int i = 0; i < W; i++) begin
      if (s2[i] == s3[i]) begin
        next_level[i] = s3[i];
      end
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      level_o <= '0;
    end else begin
      s1 <= din_i;
      s2 <= s1;
      s3 <= s2;
      level_o <= next_level;
    end
  end

  assign rise_o = next_level & ~level_o;
  assign fall_o = ~next_level & level_o;
endmodule

// ==== src/spisq_fifo.sv ====
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module spisq_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 8
) (
  input wire logic clock_i, // System clock
  input wire logic rstn_i, // Async reset, active low
  input wire logic [WIDTH-1:0] in_data_i, // Write word
  input wire logic in_valid_i, // Write request
  output logic in_ready_o, // Not full
  output logic [WIDTH-1:0] out_data_o, // Head word
  output logic out_valid_o, // Not empty
  input wire logic out_ready_i // Drain accepts head
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] rd_ptr, wr_ptr, next_rd_ptr, next_wr_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rd_ptr];

  always_comb begin
    next_wr_ptr = push ? AW'((wr_ptr == AW'(DEPTH - 1)) ? 0 : wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? AW'((rd_ptr == AW'(DEPTH - 1)) ? 0 : rd_ptr + 1'b1) : rd_ptr;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count <= '0;
    end else begin
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      count <= next_count;
    end
  end

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule

// ==== src/spisq_top.sv ====
// Serial configuration port: instruction decode and address sequencing
`timescale 1ns/1ps
// Overview of operation
// - A 16-bit instruction opens each transfer; its top bit selects read or write.
// - Next two bits give length: one, two, three bytes, or streaming.
// - Lowest thirteen instruction bits give the first register address.
// - MSB-first order shifts highest bit first and is the reset default.
// - MSB-first order decrements the address after each data byte.
// - LSB-first order shifts lowest bit first and increments the address.
// - The LSB-first selection takes effect right after its write.
// - Long instruction bits are set at reset but a write can clear them; only the long format exists.
// - Incrementing stream ends after serving the final register.
// - Decrementing stream wraps from zero to the final register, then ends.
// - Every address is stepped through, reserved ones included.
// - Streaming always ends at the final register address.
// - Write bits sampled on rising clock, readback changes on falling.
// - Writes go to a buffer; update bit of final register activates them.
// - Configuration bit zero selects shared data line or separate output.
module spisq_top (
  input wire logic clock_i, // 40 MHz system clock
  input wire logic rstn_i, // Async reset, active low
  input wire logic sclk_i, // Serial clock pin
  input wire logic csn_i, // Chip select pin, active low
  input wire logic sdio_i, // Shared data line, input side
  output logic sdio_o, // Shared data line, output value
  output logic sdio_oe_o, // Shared data line drive enable
  output logic readback_output_line_o, // Separate readback line value
  output logic readback_output_line_oe_o, // Separate readback line drive enable
  output logic [12:0] rd_addr_o, // Register address being read
  input wire logic [7:0] rd_data_i, // Register data at rd_addr_o
  output spisq_pkg::spisq_wr_s wr_data_o, // Buffered write word
  output logic wr_valid_o, // Write word available
  input wire logic wr_ready_i, // Register bank takes write word
  output logic update_o, // Pulse: activate buffered writes
  output logic overrun_o // Sticky: write byte lost to full buffer
);
  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [2:0] pin_lvl, pin_rise, pin_fall;
  logic cs_on, sck_up, sck_dn, cs_up;

  // Select lane enters inverted so that its reset value is the idle level
  spisq_sync #(.W(spisq_pkg::SYNC_W)) u_sync (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .din_i({sdio_i, !csn_i, sclk_i}),
    .level_o(pin_lvl),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  assign cs_on = pin_lvl[spisq_pkg::LANE_CSN];
  assign cs_up = pin_fall[spisq_pkg::LANE_CSN];
  assign sck_up = cs_on && pin_rise[spisq_pkg::LANE_SCLK];
  assign sck_dn = cs_on && pin_fall[spisq_pkg::LANE_SCLK];

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  spisq_pkg::spisq_state_e state, next_state;
  logic [3:0] bitcnt, next_bitcnt;
  logic [15:0] sh, next_sh, sh_step;
  logic [12:0] addr, next_addr;
  logic is_read, next_is_read;
  logic stream, next_stream;
  logic [1:0] rem, next_rem;
  logic [7:0] cfg, next_cfg;
  logic [7:0] tx, next_tx;
  logic dout, next_dout;
  logic pend_v, next_pend_v;
  spisq_pkg::spisq_wr_s pend, next_pend;
  logic next_update, next_overrun;
  logic lsb, fifo_ready;
  logic [7:0] wbyte, rbyte;
  logic byte_end;

  // Address after a served byte; decrement wraps zero to the final register
  function automatic logic [12:0] step_addr(input logic [12:0] a, input logic up);
    if (up) begin
      return a + 13'h0001;
    end
    return (a == 13'h0000) ? spisq_pkg::LAST_ADDR : a - 13'h0001;
  endfunction

  assign lsb = cfg[spisq_pkg::CFG_LSB_BIT];
  assign sh_step = lsb ? {pin_lvl[spisq_pkg::LANE_DATA], sh[15:1]} :
                         {sh[14:0], pin_lvl[spisq_pkg::LANE_DATA]};
  assign wbyte = lsb ? sh_step[15:8] : sh_step[7:0];
  assign rbyte = (addr == spisq_pkg::CFG_ADDR) ? cfg : rd_data_i;
  assign byte_end = sck_up && state == spisq_pkg::SQ_DATA && bitcnt[2:0] == spisq_pkg::BIT_LAST_DATA;

  always_comb begin
    next_state = state;
    next_bitcnt = bitcnt;
    next_sh = sh;
    next_addr = addr;
    next_is_read = is_read;
    next_stream = stream;
    next_rem = rem;
    next_cfg = cfg;
    next_tx = tx;
    next_dout = dout;
    next_pend_v = pend_v && !fifo_ready;
    next_pend = pend;
    next_update = 1'b0;
    next_overrun = overrun_o;
    if (cs_up) begin
      // Byte-boundary rise stalls the instruction or a counted transfer; a stream, done state or mid-byte rise restarts
      if (state == spisq_pkg::SQ_DONE || bitcnt[2:0] != 3'h0 ||
          (state == spisq_pkg::SQ_DATA && stream)) begin
        next_state = spisq_pkg::SQ_INSTR;
        next_bitcnt = 4'h0;
      end
    end else if (sck_up) begin
      next_sh = sh_step;
      unique case (state)
        spisq_pkg::SQ_INSTR: begin
          next_bitcnt = bitcnt + 4'h1;
          if (bitcnt == spisq_pkg::BIT_LAST_INSTR) begin
            next_state = spisq_pkg::SQ_DATA;
            next_bitcnt = 4'h0;
            next_is_read = sh_step[spisq_pkg::RW_BIT];
            next_rem = sh_step[spisq_pkg::LEN_HI:spisq_pkg::LEN_LO];
            next_stream = sh_step[spisq_pkg::LEN_HI:spisq_pkg::LEN_LO] ==
                          spisq_pkg::LEN_STREAM;
            next_addr = sh_step[12:0];
          end
        end
        spisq_pkg::SQ_DATA: begin
          next_bitcnt = bitcnt + 4'h1;
          if (bitcnt[2:0] == spisq_pkg::BIT_LAST_DATA) begin
            next_bitcnt = 4'h0;
            if (!is_read) begin
              if (addr == spisq_pkg::CFG_ADDR) begin
                next_cfg = wbyte;
              end
              if (addr == spisq_pkg::LAST_ADDR && wbyte[spisq_pkg::UPDATE_BIT]) begin
                next_update = 1'b1;
              end
              if (next_pend_v) begin
                next_overrun = 1'b1;
              end else begin
                next_pend_v = 1'b1;
                next_pend = '{addr: addr, data: wbyte};
              end
            end
            if (stream) begin
              if (addr == spisq_pkg::LAST_ADDR) begin
                next_state = spisq_pkg::SQ_DONE;
              end else begin
                next_addr = step_addr(addr, lsb);
              end
            end else if (rem == 2'h0) begin
              next_state = spisq_pkg::SQ_DONE;
            end else begin
              next_rem = rem - 2'h1;
              next_addr = step_addr(addr, lsb);
            end
          end
        end
        spisq_pkg::SQ_DONE: begin
        end
      endcase
    end else if (sck_dn && state == spisq_pkg::SQ_DATA && is_read) begin
      // Readback bits move on the falling edge
      if (bitcnt[2:0] == 3'h0) begin
        next_tx = rbyte;
        next_dout = lsb ? rbyte[0] : rbyte[7];
      end else begin
        next_tx = lsb ? {1'b0, tx[7:1]} : {tx[6:0], 1'b0};
        next_dout = lsb ? tx[1] : tx[6];
      end
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= spisq_pkg::SQ_INSTR;
      bitcnt <= 4'h0;
      sh <= 16'h0000;
      addr <= 13'h0000;
      is_read <= 1'b0;
      stream <= 1'b0;
      rem <= 2'h0;
      cfg <= spisq_pkg::CFG_RESET;
      tx <= 8'h00;
      dout <= 1'b0;
      pend_v <= 1'b0;
      pend <= '0;
      update_o <= 1'b0;
      overrun_o <= 1'b0;
    end else begin
      state <= next_state;
      bitcnt <= next_bitcnt;
      sh <= next_sh;
      addr <= next_addr;
      is_read <= next_is_read;
      stream <= next_stream;
      rem <= next_rem;
      cfg <= next_cfg;
      tx <= next_tx;
      dout <= next_dout;
      pend_v <= next_pend_v;
      pend <= next_pend;
      update_o <= next_update;
      overrun_o <= next_overrun;
    end
  end

  // ----------------------------------------------------------------
  // Write buffer toward the register bank
  // ----------------------------------------------------------------
  spisq_fifo #(.WIDTH($bits(spisq_pkg::spisq_wr_s)), .DEPTH(spisq_pkg::FIFO_DEPTH)) u_fifo (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .in_data_i(pend),
    .in_valid_i(pend_v),
    .in_ready_o(fifo_ready),
    .out_data_o(wr_data_o),
    .out_valid_o(wr_valid_o),
    .out_ready_i(wr_ready_i)
  );

  // ----------------------------------------------------------------
  // Readback pins
  // ----------------------------------------------------------------
  logic drive;
  assign drive = cs_on && state == spisq_pkg::SQ_DATA && is_read;
  assign sdio_o = dout;
  assign readback_output_line_o = dout;
  assign sdio_oe_o = drive && !cfg[spisq_pkg::CFG_SDO_BIT];
  assign readback_output_line_oe_o = drive && cfg[spisq_pkg::CFG_SDO_BIT];
  assign rd_addr_o = addr;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  logic instr_end;
  assign instr_end = sck_up && !cs_up && state == spisq_pkg::SQ_INSTR &&
                     bitcnt == spisq_pkg::BIT_LAST_INSTR;

  sequence instr_done_s;
    instr_end ##1 state == spisq_pkg::SQ_DATA;
  endsequence

  sequence mid_step_s;
    byte_end && !cs_up && (stream || rem != 2'h0) && addr != spisq_pkg::LAST_ADDR;
  endsequence

  decode_dir_a: assert property (instr_done_s |-> is_read == $past(sh_step[15]))
    else $error("direction bit not decoded");
  length_code_a: assert property (instr_done_s |->
    stream == ($past(sh_step[14:13]) == 2'h3) && rem == $past(sh_step[14:13]))
    else $error("length code not decoded");
  start_addr_a: assert property (instr_end |=> addr == $past(sh_step[12:0]))
    else $error("start address not taken");
  addr_dec_a: assert property ((mid_step_s and (!lsb && addr != 13'h0000)) |=>
    addr == $past(addr) - 13'h0001)
    else $error("address did not decrement");
  addr_inc_a: assert property ((mid_step_s and lsb) |=> addr == $past(addr) + 13'h0001)
    else $error("address did not increment");
  stream_end_a: assert property (byte_end && !cs_up && stream &&
    addr == spisq_pkg::LAST_ADDR |=> state == spisq_pkg::SQ_DONE ##1 !drive || cs_on)
    else $error("stream did not stop at final register");
  wrap_last_a: assert property (byte_end && !cs_up && stream && !lsb &&
    addr == 13'h0000 |=> addr == spisq_pkg::LAST_ADDR && state == spisq_pkg::SQ_DATA)
    else $error("decrement did not wrap to final register");
  abort_odd_a: assert property (cs_up && bitcnt[2:0] != 3'h0 |=>
    state == spisq_pkg::SQ_INSTR && bitcnt == 4'h0)
    else $error("odd chip select rise did not reset");
  cfg_now_a: assert property (byte_end && !cs_up && !is_read &&
    addr == spisq_pkg::CFG_ADDR |=> lsb == $past(wbyte[1]))
    else $error("bit order did not change at once");
  update_pulse_a: assert property (byte_end && !cs_up && !is_read &&
    addr == spisq_pkg::LAST_ADDR && wbyte[0] |=> update_o ##1 !update_o)
    else $error("update pulse missing");
  line_select_a: assert property (!(sdio_oe_o && readback_output_line_oe_o))
    else $error("both readback lines driven");
  count_end_a: assert property (byte_end && !cs_up && !stream && rem == 2'h0 |=>
    state == spisq_pkg::SQ_DONE)
    else $error("counted transfer did not end");
  shift_rise_a: assert property (!sck_up |=> sh == $past(sh))
    else $error("bits shifted off the rising edge");
  wr_queue_a: assert property (byte_end && !cs_up && !is_read &&
    (!pend_v || fifo_ready) |=> pend_v && pend.addr == $past(addr) &&
    pend.data == $past(wbyte))
    else $error("written byte not buffered");
  stall_keep_a: assert property (cs_up && bitcnt[2:0] == 3'h0 && !stream &&
    state == spisq_pkg::SQ_DATA |=> state == spisq_pkg::SQ_DATA && bitcnt == 4'h0)
    else $error("stall on byte boundary lost the transfer");
  rd_load_a: assert property (sck_dn && !cs_up && state == spisq_pkg::SQ_DATA &&
    is_read && bitcnt[2:0] == 3'h0 |=> tx == $past(rbyte))
    else $error("readback byte not loaded on falling edge");
  oe_idle_a: assert property (!cs_on |-> !sdio_oe_o && !readback_output_line_oe_o)
    else $error("readback line driven outside a frame");
endmodule

// ==== tb/spisq_host_model.sv ====
// Host-side serial master model that drives the configuration port
`timescale 1ns/1ps
module spisq_host_model (
  input wire logic clock_i, // System clock
  input wire logic sdio_i, // Resolved shared data line
  input wire logic rbl_i, // Separate readback line
  output logic sclk_o, // Serial clock, low outside frames
  output logic csn_o, // Chip select, active low
  output logic sdio_o // Host value for the shared line
);
  logic [7:0] tx [16];
  logic [7:0] rx [16];

  initial begin
    sclk_o = 1'b0;
    csn_o = 1'b1;
    sdio_o = 1'b0;
  end

  task automatic edges(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  // ----------------------------------------------------------------
  // One link bit, 200 ns: data set after the fall, taken on the rise
  // ----------------------------------------------------------------
  task automatic bit_io(input logic d, input logic rel, input logic sep, output logic got);
    sdio_o <= rel ? ~sdio_o : d;
    edges(4);
    sclk_o <= 1'b1;
    edges(3);
    // Take readback a cycle before the fall, clear of the edge that ends a byte
    got = sep ? rbl_i : sdio_i;
    edges(1);
    sclk_o <= 1'b0;
  endtask

  // Released line toggles so that a stale value never reads as valid
  task automatic xfer(input logic lsb, input logic sep, input logic [15:0] instr,
                      input int nb, input int cut);
    logic g;
    logic [7:0] b;
    csn_o <= 1'b0;
    edges(8);
    for (int i = 0; i < 16; i++) begin
      bit_io(instr[lsb ? i : 15 - i], 1'b0, sep, g);
    end
    for (int k = 0; k < nb; k++) begin
      for (int i = 0; i < 8; i++) begin
        bit_io(tx[k][lsb ? i : 7 - i], instr[15], sep, g);
        b[lsb ? i : 7 - i] = g;
      end
      rx[k] = b;
    end
    for (int i = 0; i < cut; i++) begin
      bit_io(1'b1, 1'b0, sep, g);
    end
    edges(4);
    csn_o <= 1'b1;
    edges(16);
  endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the serial port instruction sequencer
`timescale 1ns/1ps
module testbench;
  logic clock_i;
  logic rstn_i;
  logic sclk;
  logic csn;
  logic sdio_h;
  logic sdio_w;
  logic sdio_d;
  logic sdio_oe;
  logic rbl;
  logic rbl_oe;
  logic [12:0] rd_addr;
  logic [7:0] rd_data;
  spisq_pkg::spisq_wr_s wr_data;
  logic wr_valid;
  logic wr_ready;
  logic upd;
  logic ovr;
  int fails = 0;
  int n_tests = 0;
  int cycles = 0;
  int upd_cnt = 0;
  logic s_oe = 1'b0;
  logic r_oe = 1'b0;

  assign sdio_w = sdio_oe ? sdio_d : sdio_h;
  // Register bank stand-in: content derived from the address
  assign rd_data = rd_addr[7:0] ^ 8'h3c;

  spisq_top u_spisq_top (.clock_i(clock_i), .rstn_i(rstn_i), .sclk_i(sclk), .csn_i(csn),
    .sdio_i(sdio_w), .sdio_o(sdio_d), .sdio_oe_o(sdio_oe), .readback_output_line_o(rbl),
    .readback_output_line_oe_o(rbl_oe), .rd_addr_o(rd_addr), .rd_data_i(rd_data),
    .wr_data_o(wr_data), .wr_valid_o(wr_valid), .wr_ready_i(wr_ready), .update_o(upd),
    .overrun_o(ovr));

  // Undriven separate line shows the inverse so a stale value cannot pass
  spisq_host_model u_spisq_host_model (.clock_i(clock_i), .sdio_i(sdio_w),
    .rbl_i(rbl_oe ? rbl : ~rbl),
    .sclk_o(sclk), .csn_o(csn), .sdio_o(sdio_h));

  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    cycles++;
    if (upd === 1'b1) upd_cnt++;
    if (sdio_oe === 1'b1) s_oe <= 1'b1;
    if (rbl_oe === 1'b1) r_oe <= 1'b1;
    if (cycles == 30000) begin
      fails++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [15:0] ins(input logic rd, input logic [1:0] len,
                                      input logic [12:0] a);
    return {rd, len, 3'h0, a[9:0]};
  endfunction

  task automatic put(input int k, input logic [7:0] v);
    u_spisq_host_model.tx[k] = v;
  endtask

  task automatic go(input logic lsb, input logic sep, input logic [15:0] i, input int nb,
                    input int cut);
    u_spisq_host_model.xfer(lsb, sep, i, nb, cut);
  endtask

  task automatic pop(input logic [12:0] a, input logic [7:0] d);
    int t;
    t = 0;
    @(negedge clock_i);
    while (wr_valid !== 1'b1 && t < 400) begin
      @(negedge clock_i);
      t++;
    end
    check("wr word", wr_data, {a, d});
    @(posedge clock_i);
    wr_ready <= 1'b1;
    @(posedge clock_i);
    wr_ready <= 1'b0;
  endtask

  task automatic empty;
    @(posedge clock_i);
    wr_ready <= 1'b1;
    repeat (24) @(posedge clock_i);
    wr_ready <= 1'b0;
    @(negedge clock_i);
    check("fifo empty", wr_valid, 1'b0);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    check("idle oe", {sdio_oe, rbl_oe}, 2'h0);
    go(1'b0, 1'b0, ins(1'b1, 2'h0, 13'h0), 1, 0);
    check("cfg reset", u_spisq_host_model.rx[0], 8'h18);
    check("shared oe", {s_oe, r_oe}, 2'h2);
    $display("reset test done");
  endtask

  task automatic t_counts;
    for (int n = 0; n < 3; n++) begin
      for (int k = 0; k < 4; k++) put(k, 8'h10 * n + k);
      go(1'b0, 1'b0, ins(1'b0, n[1:0], 13'h105), n + 2, 0);
      for (int k = 0; k <= n; k++) begin
        pop(13'h105 - k, 8'h10 * n + k);
      end
      empty();
    end
    $display("count test done");
  endtask

  task automatic t_wrap;
    put(0, 8'h41);
    put(1, 8'h42);
    put(2, 8'h18);
    put(3, 8'h01);
    put(4, 8'h55);
    put(5, 8'h66);
    upd_cnt = 0;
    go(1'b0, 1'b0, ins(1'b0, 2'h3, 13'h2), 6, 0);
    pop(13'h2, 8'h41);
    pop(13'h1, 8'h42);
    pop(13'h0, 8'h18);
    pop(13'h232, 8'h01);
    empty();
    check("update pulses", upd_cnt, 1);
    $display("wrap test done");
  endtask

  task automatic t_read;
    s_oe = 1'b0;
    go(1'b0, 1'b0, ins(1'b1, 2'h1, 13'h10), 2, 0);
    check("rd byte0", u_spisq_host_model.rx[0], 8'h10 ^ 8'h3c);
    check("rd byte1", u_spisq_host_model.rx[1], 8'h0f ^ 8'h3c);
    check("rd oe", s_oe, 1'b1);
    $display("read test done");
  endtask

  task automatic t_overrun;
    for (int k = 0; k < 10; k++) put(k, 8'h80 + k);
    go(1'b0, 1'b0, ins(1'b0, 2'h3, 13'h40), 10, 0);
    check("overrun", ovr, 1'b1);
    for (int k = 0; k < 8; k++) pop(13'h40 - k, 8'h80 + k);
    empty();
    $display("overrun test done");
  endtask

  task automatic t_lsb;
    put(0, 8'h5a);
    go(1'b0, 1'b0, ins(1'b0, 2'h0, 13'h0), 1, 0);
    pop(13'h0, 8'h5a);
    for (int k = 0; k < 4; k++) put(k, 8'h01 + k);
    upd_cnt = 0;
    go(1'b1, 1'b0, ins(1'b0, 2'h3, 13'h230), 4, 0);
    pop(13'h230, 8'h01);
    pop(13'h231, 8'h02);
    pop(13'h232, 8'h03);
    empty();
    check("lsb update", upd_cnt, 1);
    $display("lsb test done");
  endtask

  task automatic t_sep_abort;
    put(0, 8'hdb);
    go(1'b1, 1'b0, ins(1'b0, 2'h0, 13'h0), 1, 0);
    pop(13'h0, 8'hdb);
    s_oe = 1'b0;
    r_oe = 1'b0;
    go(1'b1, 1'b1, ins(1'b1, 2'h0, 13'h77), 1, 0);
    check("sep byte", u_spisq_host_model.rx[0], 8'h77 ^ 8'h3c);
    check("sep oe", {s_oe, r_oe}, 2'h1);
    go(1'b1, 1'b1, ins(1'b0, 2'h0, 13'h9), 0, 5);
    put(0, 8'h99);
    go(1'b1, 1'b1, ins(1'b0, 2'h0, 13'h8), 1, 0);
    pop(13'h8, 8'h99);
    empty();
    $display("abort test done");
  endtask

  initial begin
    rstn_i = 1'b0;
    wr_ready = 1'b0;
    repeat (16) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (8) @(posedge clock_i);
    t_reset();
    t_counts();
    t_wrap();
    t_read();
    t_overrun();
    t_lsb();
    t_sep_abort();
    stop_test();
  end
endmodule
